// >>> common/xbus_cfg.svh
// constants for the repeater expansion bus port
// What this block does
// - on a collision, drive a 10 MHz square wave onto the collision pair.
// - no collision, select-out and grant asserted: send NRZ repeated data.
// - with collision flag high, data line is 1 single-port, 0 multiport.
// - drive data when granted and active, receive if granted idle, else float.
// - an active device with a collision on its own ports drives the flag high.
// - collision flag floats when neither select-out nor grant is asserted.
// - internal mode: select-in low means an upstream device is active.
// - select-in zero sampled on the first clock after reset: high internal, low external arbiter.
// - internal mode: select-out low when active or either select-in low.
// - active while receiving, colliding, draining or extending to 96 bits.
// - external arbiter mode: select-out asserted whenever the device is active.
// - grant low marks an active device and valid flag and data.
// - multi-active low means several devices active; each jams on its own.
// - all bus logic runs from the master clock.
// - arbitration strap latched when reset is released.
`ifndef XBUS_CFG_SVH
`define XBUS_CFG_SVH
`define XBUS_CLK_MHZ      100
`define XBUS_BIT_NS       100
`define XBUS_BIT_CYC      ((`XBUS_BIT_NS * `XBUS_CLK_MHZ) / 1000)
`define XBUS_COLCLK_NS    50
`define XBUS_COLCLK_CYC   ((`XBUS_COLCLK_NS * `XBUS_CLK_MHZ) / 1000)
`define XBUS_EXT_BITS     96
`define XBUS_MODE_RST     1'b1
`endif

// >>> common/xbus_pkg.sv
// types for the repeater expansion bus port
package xbus_pkg;
    typedef enum logic {ARB_EXTERNAL, ARB_INTERNAL} arb_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_EXTEND} act_state_t;
endpackage : xbus_pkg

// >>> rtl/bit_timer.sv
// divider producing one-cycle enable pulses every div cycles
`timescale 1ns/10ps
`default_nettype none
module bit_timer
#(
    parameter int DIV = 10
)
(
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic run_i,
    output var  logic tick_o
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         nxt_tick;
    logic         tick_ff;

    initial
    begin
        if (DIV < 1)
            $error("bit_timer: DIV must be at least 1");
    end

    always_comb
    begin
        nxt_cnt  = cnt_ff;
        nxt_tick = 1'b0;
        if (!run_i)
            nxt_cnt = '0;
        else if (cnt_ff == W'(DIV - 1))
        begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
        end
        else
            nxt_cnt = cnt_ff + 1'b1;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;
endmodule : bit_timer
`default_nettype wire

// >>> rtl/xbus_port.sv
// expansion bus port: arbitration, data, collision and collision pair
`timescale 1ns/10ps
`default_nettype none
`include "xbus_cfg.svh"
module xbus_port
#(
    parameter int EXT_BITS = `XBUS_EXT_BITS
)
(
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    input  wire logic               port_rx_i,
    input  wire logic               port_col_i,
    input  wire logic               multi_port_col_i,
    input  wire logic               buf_busy_i,
    input  wire logic               tx_data_i,
    input  wire logic [1:0]         upstream_active_in_n_i,
    input  wire logic               grant_n_i,
    input  wire logic               multi_active_n_i,
    input  wire logic               expansion_data_line_i,
    input  wire logic               collision_flag_i,
    output logic                    expansion_data_line_o,
    output logic                    expansion_data_line_oe_o,
    output logic                    collision_flag_o,
    output logic                    collision_flag_oe_o,
    output logic                    active_select_out_n_o,
    output logic                    collision_pair_o,
    output logic                    collision_pair_oe_o,
    output logic                    rx_data_o,
    output logic                    rx_collision_o,
    output logic                    rx_single_port_o,
    output logic                    jam_req_o,
    output xbus_pkg::arb_mode_t     arb_mode_o
);
    import xbus_pkg::*;

    localparam int BIT_CYC = `XBUS_BIT_CYC;
    localparam int COL_CYC = `XBUS_COLCLK_CYC;
    localparam int EW      = $clog2(EXT_BITS + 1);

    initial
    begin
        if (EXT_BITS < 1 || BIT_CYC < 1 || COL_CYC < 1)
            $error("xbus_port: timing constants out of range");
    end

    arb_mode_t    mode_ff, nxt_mode;
    logic         strap_done_ff, nxt_strap_done;
    act_state_t   st_ff, nxt_st;
    logic [EW-1:0] ext_ff, nxt_ext;
    logic         xd_ff, nxt_xd;
    logic         xd_oe_ff, nxt_xd_oe;
    logic         col_ff, nxt_col;
    logic         col_oe_ff, nxt_col_oe;
    logic         sel_n_ff, nxt_sel_n;
    logic         cp_ff, nxt_cp;
    logic         cp_oe_ff, nxt_cp_oe;
    logic         rxd_ff, nxt_rxd;
    logic         rxc_ff, nxt_rxc;
    logic         rxs_ff, nxt_rxs;
    logic         jam_ff, nxt_jam;
    logic         bit_tick;
    logic         col_tick;
    logic         active;
    logic         granted;
    logic         sel_asserted;

    // shared bit clock enable, one bit per ten 100 MHz master clocks
    bit_timer #(.DIV(BIT_CYC)) u_bit (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .run_i  (1'b1),
        .tick_o (bit_tick)
    );

    // half period of the 10 MHz collision signal
    bit_timer #(.DIV(COL_CYC)) u_col (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .run_i  (port_col_i),
        .tick_o (col_tick)
    );

    // strap taken once on the first clock after release, not under reset
    always_comb
    begin
        nxt_mode       = mode_ff;
        nxt_strap_done = 1'b1;
        if (!strap_done_ff)
            nxt_mode = upstream_active_in_n_i[0] ? ARB_INTERNAL
                                                 : ARB_EXTERNAL;
    end

    // activity: receiving, colliding, draining, then extend to min length
    always_comb
    begin
        nxt_st  = st_ff;
        nxt_ext = ext_ff;
        case (st_ff)
            ST_IDLE:
            begin
                nxt_ext = '0;
                if (port_rx_i || port_col_i)
                    nxt_st = ST_SEND;
            end
            ST_SEND:
            begin
                if (bit_tick && ext_ff != EW'(EXT_BITS))
                    nxt_ext = ext_ff + 1'b1;
                if (!port_rx_i && !port_col_i && !buf_busy_i)
                    nxt_st = (ext_ff < EW'(EXT_BITS)) ? ST_EXTEND
                                                      : ST_IDLE;
            end
            ST_EXTEND:
            begin
                if (bit_tick)
                    nxt_ext = ext_ff + 1'b1;
                if (port_rx_i || port_col_i)
                    nxt_st = ST_SEND;
                else if (bit_tick && ext_ff == EW'(EXT_BITS - 1))
                    nxt_st = ST_IDLE;
            end
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    assign active       = (st_ff != ST_IDLE) || port_rx_i || port_col_i;
    assign granted      = !grant_n_i;
    assign sel_asserted = !sel_n_ff;

    // bus drive decisions, registered so pins come from flip-flops
    always_comb
    begin
        nxt_sel_n  = 1'b1;
        nxt_xd     = xd_ff;
        nxt_xd_oe  = 1'b0;
        nxt_col    = 1'b0;
        nxt_col_oe = 1'b0;
        nxt_rxd    = rxd_ff;
        nxt_rxc    = 1'b0;
        nxt_rxs    = 1'b0;
        nxt_cp     = 1'b0;
        nxt_cp_oe  = 1'b0;
        if (mode_ff == ARB_INTERNAL)
            nxt_sel_n = !(active || !upstream_active_in_n_i[0]
                          || !upstream_active_in_n_i[1]);
        else
            nxt_sel_n = !active;
        if (granted && active)
        begin
            nxt_xd_oe = 1'b1;
            if (port_col_i)
                nxt_xd = !multi_port_col_i;
            else if (sel_asserted && bit_tick)
                nxt_xd = tx_data_i;
        end
        else if (granted)
        begin
            // data sampled once per bit time while another device sends
            if (bit_tick)
                nxt_rxd = expansion_data_line_i;
            nxt_rxc = collision_flag_i;
            nxt_rxs = collision_flag_i && expansion_data_line_i;
        end
        if (sel_asserted || granted)
        begin
            nxt_col_oe = active && port_col_i;
            nxt_col    = active && port_col_i;
        end
        if (port_col_i)
        begin
            nxt_cp_oe = 1'b1;
            nxt_cp    = col_tick ? !cp_ff : cp_ff;
        end
        nxt_jam = !multi_active_n_i || port_col_i;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mode_ff       <= ARB_INTERNAL;
            strap_done_ff <= 1'b0;
            st_ff         <= ST_IDLE;
            ext_ff        <= '0;
            xd_ff         <= 1'b0;
            xd_oe_ff      <= 1'b0;
            col_ff        <= 1'b0;
            col_oe_ff     <= 1'b0;
            sel_n_ff      <= 1'b1;
            cp_ff         <= 1'b0;
            cp_oe_ff      <= 1'b0;
            rxd_ff        <= 1'b0;
            rxc_ff        <= 1'b0;
            rxs_ff        <= 1'b0;
            jam_ff        <= 1'b0;
        end
        else
        begin
            mode_ff       <= nxt_mode;
            strap_done_ff <= nxt_strap_done;
            st_ff         <= nxt_st;
            ext_ff        <= nxt_ext;
            xd_ff         <= nxt_xd;
            xd_oe_ff      <= nxt_xd_oe;
            col_ff        <= nxt_col;
            col_oe_ff     <= nxt_col_oe;
            sel_n_ff      <= nxt_sel_n;
            cp_ff         <= nxt_cp;
            cp_oe_ff      <= nxt_cp_oe;
            rxd_ff        <= nxt_rxd;
            rxc_ff        <= nxt_rxc;
            rxs_ff        <= nxt_rxs;
            jam_ff        <= nxt_jam;
        end
    end

    assign expansion_data_line_o    = xd_ff;
    assign expansion_data_line_oe_o = xd_oe_ff;
    assign collision_flag_o         = col_ff;
    assign collision_flag_oe_o      = col_oe_ff;
    assign active_select_out_n_o    = sel_n_ff;
    assign collision_pair_o         = cp_ff;
    assign collision_pair_oe_o      = cp_oe_ff;
    assign rx_data_o                = rxd_ff;
    assign rx_collision_o           = rxc_ff;
    assign rx_single_port_o         = rxs_ff;
    assign jam_req_o                = jam_ff;
    assign arb_mode_o               = mode_ff;
endmodule : xbus_port
`default_nettype wire

// >>> sim/xbus_port_monitor.sv
// assertion checker for the expansion bus port
`timescale 1ns/10ps
`default_nettype none
module xbus_port_monitor
(
    input wire logic                clk_i,
    input wire logic                nrst_i,
    input wire logic                port_rx_i,
    input wire logic                port_col_i,
    input wire logic                multi_port_col_i,
    input wire logic [1:0]          upstream_active_in_n_i,
    input wire logic                grant_n_i,
    input wire logic                expansion_data_line_o,
    input wire logic                expansion_data_line_oe_o,
    input wire logic                collision_flag_o,
    input wire logic                collision_flag_oe_o,
    input wire logic                active_select_out_n_o,
    input wire logic                collision_pair_o,
    input wire logic                collision_pair_oe_o,
    input wire xbus_pkg::arb_mode_t arb_mode_o
);
    import xbus_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    AST_LINE_FLOAT:
        assert property (grant_n_i |=> !expansion_data_line_oe_o)
        else $error("data line driven without grant");
    AST_FLAG_FLOAT:
        assert property (collision_flag_oe_o |->
            !active_select_out_n_o || !$past(grant_n_i))
        else $error("flag driven while deselected");
    AST_FLAG_SET:
        assert property (port_col_i [*3] |->
            collision_flag_o && collision_flag_oe_o)
        else $error("flag not raised on collision");
    AST_COL_KIND:
        assert property (collision_flag_o && expansion_data_line_oe_o |->
            expansion_data_line_o == !$past(multi_port_col_i))
        else $error("wrong collision kind on data line");
    AST_PAIR_RATE:
        assert property ($rose(collision_pair_o) ##4 collision_pair_oe_o
            |-> collision_pair_o ##1 (!collision_pair_o || !collision_pair_oe_o))
        else $error("collision pair half period wrong");
    AST_ACTIVE_SELECT_OUT_INT:
        assert property ((arb_mode_o == ARB_INTERNAL) [*2]
            ##0 upstream_active_in_n_i != 2'h3 |=> !active_select_out_n_o)
        else $error("select out not relayed");
    AST_ACTIVE_SELECT_OUT_EXT:
        assert property (arb_mode_o == ARB_EXTERNAL && port_rx_i
            |=> !active_select_out_n_o)
        else $error("no request while active");
    // bit tick must not slip: a new bit holds for at least the next eight clocks
    AST_BIT_HOLD:
        assert property (expansion_data_line_oe_o && !collision_flag_o
            && $past(expansion_data_line_oe_o) && $changed(expansion_data_line_o)
            |=> ($stable(expansion_data_line_o) || !expansion_data_line_oe_o)[*8])
        else $error("data bit shorter than a bit time");
endmodule : xbus_port_monitor
bind xbus_port xbus_port_monitor mon (.*);
`default_nettype wire

// >>> sim/bus_peer.sv
// neighbour device and arbiter on the far side of the expansion bus
`timescale 1ns/10ps
`default_nettype none
module bus_peer
(
    input  wire logic  clk_i,
    input  wire logic  nrst_i,
    input  wire logic  strap_i,
    input  wire logic  slow_i,
    input  wire logic  req_n_i,
    input  wire logic  act_i,
    input  wire logic  bit_i,
    input  wire logic  line_i,
    input  wire logic  line_oe_i,
    input  wire logic  flag_i,
    input  wire logic  flag_oe_i,
    output logic [1:0] sel_n_o,
    output logic       grant_n_o,
    output logic       line_o,
    output logic       flag_o
);
    logic [3:0] wait_ff;
    logic [1:0] hold_ff;
    logic       req;
    assign req = !req_n_i || act_i;
    // strap held past release so the port can sample it
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wait_ff <= 4'h0;
            hold_ff <= 2'h0;
        end
        else
        begin
            wait_ff <= req ? wait_ff + 4'(wait_ff != 4'hf) : 4'h0;
            hold_ff <= {hold_ff[0], 1'b1};
        end
    end
    assign sel_n_o   = {1'b1, hold_ff[1] ? !act_i : strap_i};
    assign grant_n_o = !(req && wait_ff >= (slow_i ? 4'h6 : 4'h1));
    // released lines fall to their resistor: data up, flag down
    assign line_o = line_oe_i ? line_i : act_i ? bit_i : 1'b1;
    assign flag_o = flag_oe_i ? flag_i : 1'b0;
endmodule : bus_peer
`default_nettype wire

// >>> sim/xbus_port_tb.sv
// self-checking bench for the expansion bus port
`timescale 1ns/10ps
`default_nettype none
module xbus_port_tb;
    import xbus_pkg::*;
    logic clk_i, nrst_i, port_rx_i, port_col_i, multi_port_col_i, buf_busy_i;
    logic tx_data_i, grant_n_i, multi_active_n_i, expansion_data_line_i;
    logic collision_flag_i, expansion_data_line_o, expansion_data_line_oe_o;
    logic collision_flag_o, collision_flag_oe_o, active_select_out_n_o;
    logic collision_pair_o, collision_pair_oe_o, rx_data_o, rx_collision_o;
    logic rx_single_port_o, jam_req_o, strap, slow, far_act, far_bit;
    logic [1:0] upstream_active_in_n_i;
    arb_mode_t arb_mode_o;
    int n_mismatch, num_checks, cycles, n_tog;
    xbus_port dut (.*);
    bus_peer peer (.clk_i(clk_i), .nrst_i(nrst_i), .strap_i(strap),
        .slow_i(slow), .req_n_i(active_select_out_n_o), .act_i(far_act),
        .bit_i(far_bit), .line_i(expansion_data_line_o),
        .line_oe_i(expansion_data_line_oe_o), .flag_i(collision_flag_o),
        .flag_oe_i(collision_flag_oe_o), .sel_n_o(upstream_active_in_n_i),
        .grant_n_o(grant_n_i), .line_o(expansion_data_line_i),
        .flag_o(collision_flag_i));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    // hang guard, well above the extension wait
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk
    task automatic do_reset(input logic st);
        nrst_i = 1'b0;
        strap = st;
        {port_rx_i, port_col_i, multi_port_col_i, buf_busy_i} = 4'h0;
        {tx_data_i, far_act, far_bit, slow} = 4'h0;
        multi_active_n_i = 1'b1;
        cyc(4);
        chk("reset select out", 1'b1, active_select_out_n_o);
        nrst_i = 1'b1;
        cyc(2);
        chk("mode", st ? ARB_INTERNAL : ARB_EXTERNAL, arb_mode_o);
    endtask : do_reset
    task automatic t_send;
        do_reset(1'b1);
        port_rx_i = 1'b1;
        tx_data_i = 1'b1;
        cyc(25);
        chk("data enable", 1'b1, expansion_data_line_oe_o);
        chk("sent one", 1'b1, expansion_data_line_o);
        tx_data_i = 1'b0;
        cyc(12);
        chk("sent zero", 1'b0, expansion_data_line_o);
        port_rx_i = 1'b0;
        cyc(850);
        chk("extend select out", 1'b0, active_select_out_n_o);
        cyc(110);
        chk("idle select out", 1'b1, active_select_out_n_o);
        chk("idle enable", 1'b0, expansion_data_line_oe_o);
        $display("t_send done");
    endtask : t_send
    task automatic t_recv;
        do_reset(1'b1);
        far_act = 1'b1;
        far_bit = 1'b1;
        cyc(12);
        chk("relay select out", 1'b0, active_select_out_n_o);
        chk("receive enable", 1'b0, expansion_data_line_oe_o);
        chk("received one", 1'b1, rx_data_o);
        far_bit = 1'b0;
        cyc(12);
        chk("received zero", 1'b0, rx_data_o);
        far_act = 1'b0;
        multi_active_n_i = 1'b0;
        cyc(2);
        chk("jam request", 1'b1, jam_req_o);
        $display("t_recv done");
    endtask : t_recv
    task automatic t_col;
        logic p;
        do_reset(1'b1);
        port_col_i = 1'b1;
        cyc(4);
        chk("flag", 1'b1, collision_flag_o);
        chk("single port", 1'b1, expansion_data_line_o);
        multi_port_col_i = 1'b1;
        cyc(2);
        chk("multiport", 1'b0, expansion_data_line_o);
        chk("pair enable", 1'b1, collision_pair_oe_o);
        n_tog = 0;
        p = collision_pair_o;
        repeat (20)
        begin
            cyc(1);
            n_tog += (collision_pair_o != p);
            p = collision_pair_o;
        end
        chk("pair toggles", 8'h04, n_tog[7:0]);
        $display("t_col done");
    endtask : t_col
    task automatic t_ext;
        do_reset(1'b0);
        slow = 1'b1;
        port_rx_i = 1'b1;
        cyc(2);
        chk("request", 1'b0, active_select_out_n_o);
        chk("float before grant", 1'b0, expansion_data_line_oe_o);
        cyc(8);
        chk("drive on grant", 1'b1, expansion_data_line_oe_o);
        $display("t_ext done");
    endtask : t_ext
    initial
    begin
        t_send();
        t_recv();
        t_col();
        t_ext();
        wrap_up();
    end
endmodule : xbus_port_tb
`default_nettype wire
